/* hdl/boot_cfg_pkg.sv */
// package: strap field positions, boot codes, memory types and rom copy constants
// assumes: used by the boot sequencer, its checker and the testbench, referenced with package::name
package boot_cfg_pkg;

  localparam int unsigned STRAP_W = 32;
  localparam int unsigned BOOT_LSB = 0;
  localparam int unsigned BOOT_W = 5;
  localparam int unsigned MEM0_LSB = 0;
  localparam int unsigned MEM0_W = 3;
  localparam int unsigned PROC_LSB = 3;
  localparam int unsigned PROC_W = 2;
  localparam int unsigned SPACE3_LSB = 28;
  localparam int unsigned SPACE2_LSB = 24;
  localparam int unsigned SPACE1_LSB = 20;
  localparam int unsigned SPACE0_LSB = 16;
  localparam int unsigned SPACE_TYPE_W = 3;
  localparam int unsigned SPACE_N = 4;
  localparam int unsigned LAST_POL_BIT = 13;
  localparam int unsigned RW_POL_BIT = 12;
  localparam int unsigned HOST_MODE_BIT = 11;
  localparam int unsigned ARB_BIT = 10;
  localparam int unsigned FIFO_STYLE_BIT = 9;
  localparam int unsigned ENDIAN_BIT = 8;

  // memory at address zero, low three bits of the boot code
  localparam logic [2:0] MEM0_SDRAM_X8 = 3'h0;
  localparam logic [2:0] MEM0_SDRAM_X16 = 3'h1;
  localparam logic [2:0] MEM0_ASYNC32 = 3'h2;
  localparam logic [2:0] MEM0_SYNC_BURST_HALF = 3'h3;
  localparam logic [2:0] MEM0_SYNC_BURST_FULL = 3'h4;
  localparam logic [2:0] MEM0_INTERNAL = 3'h5;
  localparam logic [2:0] MEM0_HOST_EXT = 3'h6;
  localparam logic [2:0] MEM0_HOST_INT = 3'h7;

  // boot process field, top two bits of the boot code
  localparam logic [1:0] PROC_NONE = 2'h0;
  localparam logic [1:0] PROC_ROM8 = 2'h1;
  localparam logic [1:0] PROC_ROM16 = 2'h2;
  localparam logic [1:0] PROC_ROM32 = 2'h3;

  localparam logic [2:0] SPACE_ASYNC32 = 3'h2;
  localparam logic [2:0] SPACE_FIFO32 = 3'h5;

  localparam logic [16:0] ROM_COPY_BYTES = 17'h10000;
  localparam logic [31:0] ROM_SRC_ADDR = 32'h0000_0000;
  localparam logic [31:0] ROM_DST_ADDR = 32'h0000_0000;

  typedef enum logic [1:0] {
    ROM_W8,
    ROM_W16,
    ROM_W32
  } rom_width_t;

  typedef struct packed {
    logic [2:0] space3_memory_type;
    logic [2:0] space2_memory_type;
    logic [2:0] space1_memory_type;
    logic [2:0] space0_memory_type;
    logic last_strobe_polarity;
    logic rw_line_polarity;
    logic host_port_mode;
    logic arbiter_enable_strap;
    logic fifo_read_style;
    logic little_endian_strap;
  } dev_cfg_t;

  typedef struct packed {
    logic [2:0] mem0_type;
    logic map_internal;
    logic sdram_width_select;
    logic sdram_at_zero;
    logic [2:0] ext_mem_reset_select;
  } mem_cfg_t;

  typedef struct packed {
    logic start;
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
    logic [16:0] byte_count;
    rom_width_t width;
    logic little_endian_words;
  } dma_req_t;

endpackage

/* hdl/boot_sequencer.sv */
// boot sequencer: latches the expansion bus straps in reset and runs the boot
// assumes: straps come from pins, dma, sdram and host sources run on clk
`timescale 1ns/10ps
`default_nettype none

module boot_sequencer #(
  parameter int unsigned STRAP_WIDTH = boot_cfg_pkg::STRAP_W,
  parameter int unsigned SPACE_COUNT = boot_cfg_pkg::SPACE_N,
  parameter logic [16:0] COPY_BYTES = boot_cfg_pkg::ROM_COPY_BYTES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [STRAP_WIDTH-1:0] expansion_data_pins,
  input wire logic sdram_init_done,
  input wire logic dma_done,
  input wire logic host_to_cpu_interrupt,
  input wire logic cpu_bus_master,
  output logic [4:0] boot_code,
  output boot_cfg_pkg::dev_cfg_t dev_cfg,
  output boot_cfg_pkg::mem_cfg_t mem_cfg,
  output boot_cfg_pkg::dma_req_t dma_req,
  output logic [SPACE_COUNT-1:0] space_async,
  output logic [SPACE_COUNT-1:0] space_fifo,
  output logic [SPACE_COUNT-1:0] space_oe_allowed,
  output logic burst_last_active_high,
  output logic write_when_rw_high,
  output logic boot_code_reserved,
  output logic device_reset_n,
  output logic cpu_reset_n,
  output logic host_boot_active,
  output logic cpu_irq_host_pending
);

  typedef enum logic [2:0] {
    ST_CAPTURE,
    ST_DECIDE,
    ST_WAIT_SDRAM,
    ST_ROM_COPY,
    ST_HOST_WAIT,
    ST_RUN
  } state_t;

  // decode of one memory type group into async and fifo flags
  function automatic logic [1:0] space_type_decode(input logic [2:0] t);
    space_type_decode = {t == boot_cfg_pkg::SPACE_FIFO32,
                         t == boot_cfg_pkg::SPACE_ASYNC32};
  endfunction

  // field positions are fixed, so the pin count and space count cannot move
  if (STRAP_WIDTH != boot_cfg_pkg::STRAP_W) begin : g_strap_check
    $error("strap width must match the fixed field layout");
  end
  if (SPACE_COUNT != boot_cfg_pkg::SPACE_N) begin : g_space_check
    $error("space count must match the four strapped groups");
  end
  // narrow rom paths assemble whole words, so the copy must be whole words too
  if (COPY_BYTES == 17'h0 || COPY_BYTES[1:0] != 2'h0) begin : g_copy_check
    $error("copy length must be a nonzero number of whole words");
  end

  logic rst_s1_q, rst_s2_q;
  logic [STRAP_WIDTH-1:0] pin_s1_q, pin_s2_q;
  logic [STRAP_WIDTH-1:0] strap_q;
  state_t state_q, state_d;
  logic [4:0] boot_code_q;
  boot_cfg_pkg::dev_cfg_t dev_cfg_q;
  boot_cfg_pkg::mem_cfg_t mem_cfg_q;
  boot_cfg_pkg::dma_req_t dma_req_q, dma_req_d;
  logic [SPACE_COUNT-1:0] space_async_q, space_fifo_q, space_oe_q;
  logic last_pol_q, rw_high_q, reserved_q;
  logic cpu_reset_n_q, cpu_reset_n_d, dev_reset_n_q, host_boot_q, irq_q;

  wire logic rst_n = rst_s2_q;

  // reset release through two flops; straps tracked while reset is held
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else if (clk_en) begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // two flops per pin: straps are board levels, not signals of the clk domain
  always_ff @(posedge clk) begin
    if (clk_en) begin
      pin_s1_q <= expansion_data_pins;
      pin_s2_q <= pin_s1_q;
    end
  end

  // strap is a plain clocked sample while reset is low, frozen afterwards
  // no reset on the strap word: it has to keep sampling while reset is low
  always_ff @(posedge clk) begin
    if (clk_en && !rst_n) begin
      strap_q <= pin_s2_q;
    end
  end

  // decode of the captured strap word
  wire logic [4:0] code_w = strap_q[boot_cfg_pkg::BOOT_LSB +: boot_cfg_pkg::BOOT_W];
  wire logic [2:0] mem0_w = code_w[boot_cfg_pkg::MEM0_LSB +: boot_cfg_pkg::MEM0_W];
  wire logic [1:0] proc_w = code_w[boot_cfg_pkg::PROC_LSB +: boot_cfg_pkg::PROC_W];
  wire logic is_host_w = (proc_w == boot_cfg_pkg::PROC_NONE) &&
                         (mem0_w == boot_cfg_pkg::MEM0_HOST_EXT ||
                          mem0_w == boot_cfg_pkg::MEM0_HOST_INT);
  wire logic is_rom_w = (proc_w != boot_cfg_pkg::PROC_NONE) &&
                        (mem0_w <= boot_cfg_pkg::MEM0_INTERNAL);
  wire logic reserved_w = (proc_w != boot_cfg_pkg::PROC_NONE) &&
                          (mem0_w > boot_cfg_pkg::MEM0_INTERNAL);
  wire logic map1_w = (mem0_w == boot_cfg_pkg::MEM0_INTERNAL) ||
                      (is_host_w && mem0_w == boot_cfg_pkg::MEM0_HOST_INT);
  wire logic sdram_w = !is_host_w && (mem0_w == boot_cfg_pkg::MEM0_SDRAM_X8 ||
                                      mem0_w == boot_cfg_pkg::MEM0_SDRAM_X16);
  wire logic [2:0] mt3_w = strap_q[boot_cfg_pkg::SPACE3_LSB +: boot_cfg_pkg::SPACE_TYPE_W];
  wire logic [2:0] mt2_w = strap_q[boot_cfg_pkg::SPACE2_LSB +: boot_cfg_pkg::SPACE_TYPE_W];
  wire logic [2:0] mt1_w = strap_q[boot_cfg_pkg::SPACE1_LSB +: boot_cfg_pkg::SPACE_TYPE_W];
  wire logic [2:0] mt0_w = strap_q[boot_cfg_pkg::SPACE0_LSB +: boot_cfg_pkg::SPACE_TYPE_W];
  wire logic [1:0] d3_w = space_type_decode(mt3_w);
  wire logic [1:0] d2_w = space_type_decode(mt2_w);
  wire logic [1:0] d1_w = space_type_decode(mt1_w);
  wire logic [1:0] d0_w = space_type_decode(mt0_w);
  wire logic fifo_style_w = strap_q[boot_cfg_pkg::FIFO_STYLE_BIT];
  // glueless style keeps output enable only for a fifo in space 3
  wire logic [SPACE_COUNT-1:0] oe_w = fifo_style_w ? {d3_w[1], 3'h0} : 4'hf;
  // the slave-side polarity applies only while someone else masters the bus
  wire logic last_pol_w = strap_q[boot_cfg_pkg::LAST_POL_BIT] && !cpu_bus_master;

  // per-space flags gathered once so the output registers stay plain copies
  wire logic [SPACE_COUNT-1:0] async_w = {d3_w[0], d2_w[0], d1_w[0], d0_w[0]};
  wire logic [SPACE_COUNT-1:0] fifo_w = {d3_w[1], d2_w[1], d1_w[1], d0_w[1]};
  wire logic rw_high_w = !strap_q[boot_cfg_pkg::RW_POL_BIT];

  boot_cfg_pkg::dev_cfg_t dev_cfg_w;
  assign dev_cfg_w = '{
    space3_memory_type: mt3_w,
    space2_memory_type: mt2_w,
    space1_memory_type: mt1_w,
    space0_memory_type: mt0_w,
    last_strobe_polarity: strap_q[boot_cfg_pkg::LAST_POL_BIT],
    rw_line_polarity: strap_q[boot_cfg_pkg::RW_POL_BIT],
    host_port_mode: strap_q[boot_cfg_pkg::HOST_MODE_BIT],
    arbiter_enable_strap: strap_q[boot_cfg_pkg::ARB_BIT],
    fifo_read_style: fifo_style_w,
    little_endian_strap: strap_q[boot_cfg_pkg::ENDIAN_BIT]
  };

  // internal memory and host boot keep the default asynchronous timing set
  boot_cfg_pkg::mem_cfg_t mem_cfg_w;
  assign mem_cfg_w = '{
    mem0_type: mem0_w,
    map_internal: map1_w,
    sdram_width_select: sdram_w && mem0_w == boot_cfg_pkg::MEM0_SDRAM_X16,
    sdram_at_zero: sdram_w,
    ext_mem_reset_select: (map1_w || is_host_w) ? boot_cfg_pkg::MEM0_ASYNC32 : mem0_w
  };

  // a 32-bit rom needs no assembly; narrow widths are packed little-endian
  wire boot_cfg_pkg::rom_width_t width_w =
    (proc_w == boot_cfg_pkg::PROC_ROM8) ? boot_cfg_pkg::ROM_W8 :
    (proc_w == boot_cfg_pkg::PROC_ROM16) ? boot_cfg_pkg::ROM_W16 : boot_cfg_pkg::ROM_W32;

  // host interrupts are only pending once the cpu runs
  wire logic irq_w = cpu_reset_n_q && host_to_cpu_interrupt;
  wire logic host_wait_w = (state_d == ST_HOST_WAIT);

  // boot sequence
  always_comb begin
    state_d = state_q;
    cpu_reset_n_d = cpu_reset_n_q;
    dma_req_d = dma_req_q;
    dma_req_d.start = 1'b0;
    case (state_q)
      ST_CAPTURE: state_d = ST_DECIDE;
      ST_DECIDE: begin
        if (is_host_w) begin
          state_d = ST_HOST_WAIT;
        end else if (is_rom_w) begin
          state_d = ST_ROM_COPY;
          dma_req_d = '{start: 1'b1, src_addr: boot_cfg_pkg::ROM_SRC_ADDR,
                        dst_addr: boot_cfg_pkg::ROM_DST_ADDR,
                        byte_count: COPY_BYTES,
                        width: width_w, little_endian_words: 1'b1};
        end else if (reserved_w) begin
          // a reserved code parks here with the cpu held until the next reset
          state_d = ST_DECIDE;
        end else begin
          state_d = ST_WAIT_SDRAM;
        end
      end
      ST_WAIT_SDRAM: begin
        // memory other than sdram passes straight through one cycle later
        if (!sdram_w || sdram_init_done) begin
          state_d = ST_RUN;
          cpu_reset_n_d = 1'b1;
        end
      end
      ST_ROM_COPY: begin
        // copy done is only heard here, so a stray done elsewhere is harmless
        if (dma_done) begin
          state_d = ST_RUN;
          cpu_reset_n_d = 1'b1;
        end
      end
      ST_HOST_WAIT: begin
        if (host_to_cpu_interrupt) begin
          state_d = ST_RUN;
          cpu_reset_n_d = 1'b1;
        end
      end
      ST_RUN: state_d = ST_RUN;
      default: state_d = ST_CAPTURE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_CAPTURE;
      cpu_reset_n_q <= 1'b0;
      dma_req_q <= '0;
      dev_reset_n_q <= 1'b0;
      host_boot_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      cpu_reset_n_q <= cpu_reset_n_d;
      dma_req_q <= dma_req_d;
      // the rest of the device leaves reset one edge after the internal release
      dev_reset_n_q <= 1'b1;
      host_boot_q <= host_wait_w;
      irq_q <= irq_w;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_code_q <= 5'h00;
      dev_cfg_q <= '0;
      mem_cfg_q <= '0;
      space_async_q <= '0;
      space_fifo_q <= '0;
      space_oe_q <= '0;
      last_pol_q <= 1'b0;
      rw_high_q <= 1'b0;
      reserved_q <= 1'b0;
    end else if (clk_en) begin
      // reloaded every cycle from the frozen strap word; only the burst last polarity moves, with cpu_bus_master
      boot_code_q <= code_w;
      dev_cfg_q <= dev_cfg_w;
      mem_cfg_q <= mem_cfg_w;
      space_async_q <= async_w;
      space_fifo_q <= fifo_w;
      space_oe_q <= oe_w;
      last_pol_q <= last_pol_w;
      rw_high_q <= rw_high_w;
      reserved_q <= reserved_w;
    end
  end

  assign boot_code = boot_code_q;
  assign dev_cfg = dev_cfg_q;
  assign mem_cfg = mem_cfg_q;
  assign dma_req = dma_req_q;
  assign space_async = space_async_q;
  assign space_fifo = space_fifo_q;
  assign space_oe_allowed = space_oe_q;
  assign burst_last_active_high = last_pol_q;
  assign write_when_rw_high = rw_high_q;
  assign boot_code_reserved = reserved_q;
  assign device_reset_n = dev_reset_n_q;
  assign cpu_reset_n = cpu_reset_n_q;
  assign host_boot_active = host_boot_q;
  assign cpu_irq_host_pending = irq_q;

endmodule

`default_nettype wire

/* verification/boot_seq_assertions.sv */
// checker: decode and sequencing relations at the boot sequencer ports
// assumes: bound to boot_sequencer; one clock, resetn active low
`timescale 1ns/10ps
`default_nettype none
module boot_seq_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cpu_bus_master,
  input wire logic host_to_cpu_interrupt,
  input wire logic [4:0] boot_code,
  input wire boot_cfg_pkg::dev_cfg_t dev_cfg,
  input wire boot_cfg_pkg::mem_cfg_t mem_cfg,
  input wire boot_cfg_pkg::dma_req_t dma_req,
  input wire logic [3:0] space_async,
  input wire logic burst_last_active_high,
  input wire logic boot_code_reserved,
  input wire logic device_reset_n,
  input wire logic cpu_reset_n,
  input wire logic host_boot_active,
  input wire logic cpu_irq_host_pending
);
  wire logic [3:0] async_exp = {dev_cfg.space3_memory_type == 3'h2,
    dev_cfg.space2_memory_type == 3'h2, dev_cfg.space1_memory_type == 3'h2,
    dev_cfg.space0_memory_type == 3'h2};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_cfg_held: assert property (
    device_reset_n && $past(device_reset_n) |-> $stable(dev_cfg))
    else $error("settings moved after capture");
  a_mem_zero: assert property (
    device_reset_n && !boot_code_reserved |-> mem_cfg.mem0_type == boot_code[2:0]
    && mem_cfg.map_internal == (boot_code[2:0] == 3'h5 || boot_code == 5'h07))
    else $error("memory at zero wrong");
  a_async_map: assert property (
    device_reset_n |-> space_async == async_exp)
    else $error("async space decode wrong");
  a_master_low: assert property (
    cpu_bus_master |=> !burst_last_active_high)
    else $error("burst last high while master");
  a_reserved_stall: assert property (
    boot_code_reserved |-> !cpu_reset_n)
    else $error("cpu runs on reserved code");
  a_cpu_last: assert property (
    cpu_reset_n |-> device_reset_n)
    else $error("cpu out of reset before device");
  a_no_pending: assert property (
    !cpu_reset_n |-> !cpu_irq_host_pending)
    else $error("host interrupt pending in reset");
  a_copy_pulse: assert property (
    dma_req.start |-> !cpu_reset_n ##1 !dma_req.start)
    else $error("copy start not a held pulse");
  a_host_release: assert property (
    host_boot_active && host_to_cpu_interrupt |=> cpu_reset_n)
    else $error("host interrupt did not release cpu");
endmodule
bind boot_sequencer boot_seq_chk chk_u (.clk, .resetn, .cpu_bus_master,
  .host_to_cpu_interrupt, .boot_code, .dev_cfg, .mem_cfg, .dma_req, .space_async,
  .burst_last_active_high, .boot_code_reserved, .device_reset_n, .cpu_reset_n,
  .host_boot_active, .cpu_irq_host_pending);
`default_nettype wire

/* verification/boot_host_model.sv */
// partner: board strap resistors and the external host at the boot pins
// assumes: pins matter only while the device is held in reset
`timescale 1ns/10ps
`default_nettype none
module boot_host_model (
  input wire logic clk,
  input wire logic device_reset_n,
  input wire logic init_done,
  input wire logic [31:0] strap,
  output logic [31:0] pins,
  output logic host_irq
);
  logic [31:0] traffic_q = 32'h5a5a_a5a5;
  logic irq_q = 1'b0;
  // reserved pins sit on pull-downs whatever the strap asks for
  wire logic [31:0] pulled = strap & 32'h7777_3f1f;
  // after release the pins carry traffic that changes every cycle
  assign pins = device_reset_n ? traffic_q : pulled;
  assign host_irq = irq_q;
  always_ff @(posedge clk) begin
    traffic_q <= traffic_q + 32'h9e37_79b9;
    irq_q <= init_done;
  end
endmodule
`default_nettype wire

/* verification/boot_sequencer_test.sv */
// testbench: strap capture and the three boot processes
// assumes: design and host model share the 20 MHz clock, clk_en held high
`timescale 1ns/10ps
`default_nettype none
module boot_sequencer_test;
  logic clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, sdram_init_done = 1'b0;
  logic dma_done = 1'b0, cpu_bus_master = 1'b0, init_done = 1'b0;
  logic [31:0] strap = 32'h0, pins;
  logic host_irq;
  logic [4:0] boot_code;
  boot_cfg_pkg::dev_cfg_t dev_cfg;
  boot_cfg_pkg::mem_cfg_t mem_cfg;
  boot_cfg_pkg::dma_req_t dma_req;
  logic [3:0] space_async, space_fifo, space_oe_allowed;
  logic burst_last_active_high, write_when_rw_high, boot_code_reserved;
  logic device_reset_n, cpu_reset_n, host_boot_active, cpu_irq_host_pending;
  int errors = 0, num_checks = 0, cycles = 0;

  always #25 clk = ~clk;

  boot_host_model host_u (.clk, .device_reset_n, .init_done, .strap, .pins, .host_irq);
  boot_sequencer dut_u (.clk, .resetn, .clk_en, .expansion_data_pins(pins),
    .sdram_init_done, .dma_done, .host_to_cpu_interrupt(host_irq), .cpu_bus_master,
    .boot_code, .dev_cfg, .mem_cfg, .dma_req, .space_async, .space_fifo,
    .space_oe_allowed, .burst_last_active_high, .write_when_rw_high, .boot_code_reserved,
    .device_reset_n, .cpu_reset_n, .host_boot_active, .cpu_irq_host_pending);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // leaves the bench just after the first edge with settings valid
  task automatic boot(input logic [31:0] s);
    tick(1);
    resetn = 1'b0;
    {sdram_init_done, dma_done, init_done, cpu_bus_master} = 4'h0;
    strap = s;
    tick(8);
    resetn = 1'b1;
    tick(3);
  endtask

  task automatic cfg_scn(input logic [31:0] s);
    logic [2:0] ty;
    boot(s);
    check("boot_code", boot_code, s[4:0]);
    check("dev_cfg", dev_cfg, {s[30:28], s[26:24], s[22:20], s[18:16], s[13:8]});
    check("rw_sense", write_when_rw_high, !s[12]);
    for (int n = 0; n < 4; n++) begin
      ty = s[16 + 4 * n +: 3];
      check("async", space_async[n], ty == 3'h2);
      check("fifo", space_fifo[n], ty == 3'h5);
      check("oe", space_oe_allowed[n], !s[9] || (n == 3 && ty == 3'h5));
    end
    tick(1);
    check("last_slave", burst_last_active_high, s[13]);
    cpu_bus_master = 1'b1;
    tick(2);
    check("last_master", burst_last_active_high, 1'b0);
    check("cfg_held", dev_cfg, {s[30:28], s[26:24], s[22:20], s[18:16], s[13:8]});
  endtask

  task automatic noboot_scn(input logic [2:0] lo);
    boot({29'h0, lo});
    check("mem0", mem_cfg.mem0_type, lo);
    check("map1", mem_cfg.map_internal, lo == 3'h5);
    check("sdram0", mem_cfg.sdram_at_zero, lo < 3'h2);
    check("ext_reset", mem_cfg.ext_mem_reset_select, lo == 3'h5 ? 3'h2 : lo);
    if (lo < 3'h2) begin
      check("width", mem_cfg.sdram_width_select, lo[0]);
      tick(6);
      check("cpu_wait", cpu_reset_n, 1'b0);
      sdram_init_done = 1'b1;
    end else begin
      tick(1);
      check("cpu_early", cpu_reset_n, 1'b0);
    end
    tick(1);
    check("cpu_run", cpu_reset_n, 1'b1);
  endtask

  task automatic rom_scn(input logic [1:0] p, input logic [2:0] lo);
    boot({27'h0, p, lo});
    tick(1);
    check("dma_start", dma_req.start, 1'b1);
    check("dma_bytes", dma_req.byte_count, 17'h10000);
    check("dma_dst", dma_req.dst_addr, 32'h0);
    check("dma_src", dma_req.src_addr, boot_cfg_pkg::ROM_SRC_ADDR);
    check("dma_width", dma_req.width, p == 2'h1 ? boot_cfg_pkg::ROM_W8 :
      p == 2'h2 ? boot_cfg_pkg::ROM_W16 : boot_cfg_pkg::ROM_W32);
    check("dma_le", dma_req.little_endian_words, 1'b1);
    tick(1);
    check("dma_pulse", dma_req.start, 1'b0);
    init_done = 1'b1;
    tick(4);
    check("cpu_copy", cpu_reset_n, 1'b0);
    check("irq_quiet", cpu_irq_host_pending, 1'b0);
    dma_done = 1'b1;
    tick(1);
    check("cpu_run", cpu_reset_n, 1'b1);
  endtask

  task automatic host_scn(input logic [2:0] lo);
    boot({29'h0, lo});
    tick(2);
    check("map1", mem_cfg.map_internal, lo[0]);
    check("reserved", boot_code_reserved, 1'b0);
    check("host_wait", host_boot_active, 1'b1);
    check("dev_run", device_reset_n, 1'b1);
    dma_done = 1'b1;
    tick(3);
    check("cpu_held", cpu_reset_n, 1'b0);
    init_done = 1'b1;
    tick(1);
    check("cpu_early", cpu_reset_n, 1'b0);
    tick(1);
    check("cpu_run", cpu_reset_n, 1'b1);
    check("irq_in_reset", cpu_irq_host_pending, 1'b0);
  endtask

  task automatic reserved_scn(input logic [4:0] code);
    boot({27'h0, code});
    tick(2);
    check("reserved", boot_code_reserved, 1'b1);
    {dma_done, init_done, sdram_init_done} = 3'h7;
    tick(6);
    check("cpu_stall", cpu_reset_n, 1'b0);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    cfg_scn(32'h5205_2b02);
    cfg_scn(32'h2552_1402);
    for (int c = 0; c < 6; c++) noboot_scn(3'(c));
    for (int p = 1; p < 4; p++) rom_scn(2'(p), 3'(p + 2));
    host_scn(3'h6);
    host_scn(3'h7);
    reserved_scn(5'h0e);
    reserved_scn(5'h1f);
    final_report();
  end
endmodule
`default_nettype wire
